// >>> core/sap_pkg.sv
// Constants and types for the strap, phase and sequencing block.
// Assumes a 25 MHz clock and a plain synchronous register port.
package sap_pkg;
  localparam int CLK_MHZ = 25;
  // Bit time on the shared event line, well above the ~1 us pull-up rise
  localparam int EV_BIT_NS = 4000;
  localparam int EV_BIT_CYC = (EV_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] EV_LAST = 7'(EV_BIT_CYC - 1);
  localparam logic [6:0] EV_MID = 7'(EV_BIT_CYC / 2);
  localparam logic [3:0] EV_FRAME_LAST = 4'h9;
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam logic [4:0] ADDR_IDX_MAX = 5'h1D;
  localparam logic [4:0] PHASE_MAX = 5'h10;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PHASE = 4'h1;
  localparam logic [3:0] REG_PRED = 4'h2;
  localparam logic [3:0] REG_SUCC = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STRAP = 4'h5;
  localparam int CTRL_OVR = 0;
  localparam int CTRL_CHAIN = 1;
  localparam int CTRL_FOLLOW = 2;
  localparam int CTRL_RESTART = 3;
  localparam int LINK_VLD = 7;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam logic [4:0] PHASE_RST = 5'h00;
  localparam logic [7:0] LINK_RST = 8'h00;
  typedef enum logic [1:0] {EV_PG = 2'b00, EV_OFF = 2'b01, EV_FLT = 2'b10} sap_ev_t;
  typedef enum logic [2:0] {
    ROLE_NONE = 3'b000, ROLE_FIRST = 3'b001, ROLE_LAST = 3'b010,
    ROLE_MID = 3'b011, ROLE_TRACK = 3'b100
  } sap_role_t;
  typedef enum logic [1:0] {SYNC_IN = 2'b00, SYNC_AUTO = 2'b01, SYNC_OUT = 2'b10} sap_sync_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_WAIT_UP = 3'b001, ST_RAMP = 3'b010, ST_ON = 3'b011,
    ST_WAIT_DN = 3'b100, ST_FALL = 3'b101, ST_FAULT = 3'b110
  } sap_state_t;
  // Strap reading: level 0 low, 1 open, 2 high; index counts resistor steps
  typedef struct packed {
    logic res_fit;
    logic [1:0] level;
    logic [4:0] index;
  } sap_strap_t;
  typedef struct packed {
    sap_role_t role;
    sap_sync_t sync;
  } sap_cfg_t;
endpackage

// >>> core/sap_seq.sv
// Strap decode, phase offset and multi-device power sequencer.
// Straps are steady from reset; event line is a wired-low shared net.
`timescale 1ns/1ns
// Function
// - Address strap level gives 0x20, 0x21, 0x22
// - Resistor strap gives 0x20 to 0x3D ascending
// - Address held right-justified in seven bits
// - One shared wired event line among peers
// - Default phase is address times 45 degrees
// - Upper address bits ignored for phase
// - Written phase overrides, 22.5 degree steps
// - Autonomous mode sequences only via event line
// - Autonomous mode forces address-derived phase
// - Config strap in threes selects sync mode
// - First-group config strap: first, no tracking
// - Last-group config strap: last, no tracking
// - Middle-group config strap: middle, no tracking
// - Tracking group: no sequencing, tracking on
// - Power-up proceeds in ascending address order
// - Power-down proceeds in descending address order
// - Written predecessor and successor define chain
// - Own shutdown fault is broadcast on line
module sap_seq
  import sap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sap_strap_t addr_strap,
  input wire sap_strap_t cfg_strap,
  input wire logic enable,
  input wire logic pgood,
  input wire logic off_done,
  input wire logic fault,
  input wire logic ev_in,
  output logic ev_out,
  output logic ev_oe_n,
  output logic run,
  output logic track_en,
  output sap_sync_t sync_mode,
  output logic [6:0] bus_addr,
  output logic [4:0] phase,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata
);
  function automatic logic [6:0] decode_addr(input sap_strap_t s);
    logic [4:0] i;
    i = (s.index > ADDR_IDX_MAX) ? ADDR_IDX_MAX : s.index;
    if (s.res_fit)
      decode_addr = ADDR_BASE + {2'b00, i};
    else
      decode_addr = ADDR_BASE + {5'b00000, s.level};
  endfunction

  function automatic sap_cfg_t decode_cfg(input sap_strap_t s);
    logic [4:0] code;
    sap_cfg_t c;
    code = s.res_fit ? 5'h03 + s.index : {3'b000, s.level};
    c.sync = sap_sync_t'(2'(code % 5'h03));
    case (code / 5'h03)
      5'h02: c.role = ROLE_FIRST;
      5'h03: c.role = ROLE_LAST;
      5'h04: c.role = ROLE_MID;
      5'h05: c.role = ROLE_TRACK;
      default: c.role = ROLE_NONE;
    endcase
    decode_cfg = c;
  endfunction

  logic loaded;
  sap_cfg_t cfg;
  logic [3:0] ctrl;
  logic [4:0] phase_reg;
  logic [7:0] pred_reg;
  logic [7:0] succ_reg;
  sap_state_t state;
  sap_state_t next_state;
  logic pred_up;
  logic succ_dn;
  logic rx_busy;
  logic [6:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh;
  logic rx_valid;
  sap_ev_t rx_type;
  logic [6:0] rx_src;
  logic tx_pend;
  sap_ev_t tx_type;
  logic tx_act;
  logic q_req;
  sap_ev_t q_type;

  // Straps caught in the first cycle after reset release
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      loaded <= 1'b0;
      bus_addr <= ADDR_BASE;
      cfg <= '{ROLE_NONE, SYNC_IN};
    end
    else if (!loaded)
    begin
      loaded <= 1'b1;
      bus_addr <= decode_addr(addr_strap);
      cfg <= decode_cfg(cfg_strap);
    end
  end

  wire chain = ctrl[CTRL_CHAIN];
  wire auto_mode = !chain && (cfg.role inside {ROLE_FIRST, ROLE_LAST, ROLE_MID});
  wire seq_on = auto_mode || chain;
  // Chain neighbours are assumed gap-free in autonomous mode
  wire [6:0] pred_addr = chain ? pred_reg[6:0] : 7'(bus_addr - 7'h01);
  wire [6:0] succ_addr = chain ? succ_reg[6:0] : 7'(bus_addr + 7'h01);
  wire has_pred = chain ? pred_reg[LINK_VLD] : (auto_mode && cfg.role != ROLE_FIRST);
  wire has_succ = chain ? succ_reg[LINK_VLD] : (auto_mode && cfg.role != ROLE_LAST);
  wire [4:0] phase_auto = {1'b0, bus_addr[2:0], 1'b0};
  wire use_ovr = ctrl[CTRL_OVR] && !auto_mode;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      phase <= PHASE_RST;
    else
      phase <= use_ovr ? phase_reg : phase_auto;
  end

  assign track_en = cfg.role == ROLE_TRACK;
  assign sync_mode = cfg.sync;

  // Register port
  wire wr_ctrl = reg_we && reg_addr == REG_CTRL;
  wire wr_phase = reg_we && reg_addr == REG_PHASE && reg_wdata[4:0] <= PHASE_MAX;
  wire wr_pred = reg_we && reg_addr == REG_PRED;
  wire wr_succ = reg_we && reg_addr == REG_SUCC;
  wire [15:0] status_word = {3'b000, phase, 1'b0, tx_pend, succ_dn, pred_up, run, state};
  wire [15:0] strap_word = {2'b00, cfg.sync, 1'b0, cfg.role, 1'b0, bus_addr};
  logic [15:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      REG_CTRL: rd_mux = {12'h000, ctrl};
      REG_PHASE: rd_mux = {11'h000, phase_reg};
      REG_PRED: rd_mux = {8'h00, pred_reg};
      REG_SUCC: rd_mux = {8'h00, succ_reg};
      REG_STATUS: rd_mux = status_word;
      REG_STRAP: rd_mux = strap_word;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RST;
      phase_reg <= PHASE_RST;
      pred_reg <= LINK_RST;
      succ_reg <= LINK_RST;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata[3:0];
      if (wr_phase)
        phase_reg <= reg_wdata[4:0];
      if (wr_pred)
        pred_reg <= reg_wdata[7:0];
      if (wr_succ)
        succ_reg <= reg_wdata[7:0];
      reg_rdata <= reg_re ? rd_mux : 16'h0000;
    end
  end

  // Event line receiver; own transmissions are timed by it as well
  wire samp = rx_busy && rx_cnt == EV_MID;
  wire [9:0] frame = {1'b0, tx_type, bus_addr};
  wire fbit = frame[4'(EV_FRAME_LAST - rx_bit)];
  wire lose = samp && tx_act && fbit && !ev_in;
  wire rx_end = samp && rx_bit == EV_FRAME_LAST;
  // Idle taken from the receiver, not the live wire: our own pull feeds back into ev_in
  wire tx_go = tx_pend && !tx_act && !rx_busy && loaded;
  wire sent = rx_end && tx_act && !lose;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 7'h00;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
    end
    else if (!rx_busy)
    begin
      rx_busy <= !ev_in;
      rx_cnt <= 7'h00;
      rx_bit <= 4'h0;
    end
    else
    begin
      rx_cnt <= (rx_cnt == EV_LAST) ? 7'h00 : rx_cnt + 7'h01;
      if (samp)
        rx_sh <= {rx_sh[7:0], ev_in};
      if (samp && rx_bit == 4'h0 && ev_in)
        rx_busy <= 1'b0;
      else if (rx_cnt == EV_LAST)
      begin
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == EV_FRAME_LAST)
          rx_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_valid <= 1'b0;
      rx_type <= EV_PG;
      rx_src <= 7'h00;
    end
    else
    begin
      rx_valid <= rx_end && {rx_sh[5:0], ev_in} != bus_addr;
      if (rx_end)
      begin
        rx_type <= sap_ev_t'(rx_sh[7:6]);
        rx_src <= {rx_sh[5:0], ev_in};
      end
    end
  end

  // Transmitter: losing a high bit to a peer retries after the frame
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_pend <= 1'b0;
      tx_type <= EV_PG;
      tx_act <= 1'b0;
    end
    else
    begin
      tx_pend <= q_req || (tx_pend && !sent);
      if (q_req)
        tx_type <= q_type;
      if (tx_go)
        tx_act <= 1'b1;
      else if (lose || rx_end || !rx_busy)
        tx_act <= 1'b0;
    end
  end

  assign ev_out = 1'b0;
  assign ev_oe_n = !(tx_go || (tx_act && rx_busy && !fbit));

  // Neighbour flags; a new event wins over a clear in the same cycle
  wire from_pred = rx_valid && has_pred && rx_src == pred_addr;
  wire from_succ = rx_valid && has_succ && rx_src == succ_addr;
  wire peer_flt = rx_valid && rx_type == EV_FLT;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pred_up <= 1'b0;
      succ_dn <= 1'b0;
    end
    else
    begin
      pred_up <= (from_pred && rx_type == EV_PG)
        || (pred_up && !(from_pred || state == ST_FAULT));
      succ_dn <= (from_succ && rx_type == EV_OFF)
        || (succ_dn && !from_succ);
    end
  end

  // Sequencer
  always_comb
  begin
    next_state = state;
    q_req = 1'b0;
    q_type = EV_PG;
    case (state)
      ST_OFF:
        if (enable && loaded)
          next_state = ST_WAIT_UP;
      ST_WAIT_UP:
        if (!enable)
          next_state = ST_OFF;
        else if (!has_pred || pred_up)
          next_state = ST_RAMP;
      ST_RAMP, ST_ON:
        if (fault)
        begin
          next_state = ST_FAULT;
          q_req = 1'b1;
          q_type = EV_FLT;
        end
        else if (peer_flt && ctrl[CTRL_FOLLOW])
          next_state = ST_FAULT;
        else if (state == ST_RAMP && pgood)
        begin
          next_state = ST_ON;
          q_req = seq_on;
          q_type = EV_PG;
        end
        else if (state == ST_ON && !enable)
          next_state = ST_WAIT_DN;
      ST_WAIT_DN:
        if (enable)
          next_state = ST_ON;
        else if (!has_succ || succ_dn)
          next_state = ST_FALL;
      ST_FALL:
        if (off_done)
        begin
          next_state = ST_OFF;
          q_req = seq_on;
          q_type = EV_OFF;
        end
      ST_FAULT:
        if (off_done && !fault && (ctrl[CTRL_RESTART] || !enable))
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
  end

  wire next_run = next_state inside {ST_RAMP, ST_ON, ST_WAIT_DN};
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_OFF;
      run <= 1'b0;
    end
    else
    begin
      state <= next_state;
      run <= next_run;
    end
  end

  // Checks
  AST_ADDR_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    $rose(loaded) && !$past(addr_strap.res_fit) |->
      bus_addr == 7'(ADDR_BASE + {5'b00000, $past(addr_strap.level)}))
    else $error("Level strap address wrong");
  AST_ADDR_RES: assert property (@(posedge mclk) disable iff (rst)
    $rose(loaded) && $past(addr_strap.res_fit) |-> bus_addr == (($past(addr_strap.index)
      > ADDR_IDX_MAX) ? 7'h3D : 7'(ADDR_BASE + {2'b00, $past(addr_strap.index)}))
      && bus_addr >= ADDR_BASE && bus_addr <= 7'h3D)
    else $error("Resistor strap address wrong");
  AST_PHASE_AUTO: assert property (@(posedge mclk) disable iff (rst)
    auto_mode |=> phase == {1'b0, $past(bus_addr[2:0]), 1'b0})
    else $error("Autonomous phase not from address");
  AST_PHASE_OVR: assert property (@(posedge mclk) disable iff (rst)
    ctrl[CTRL_OVR] && !auto_mode |=> phase == $past(phase_reg))
    else $error("Phase override not applied");
  AST_UP_ORDER: assert property (@(posedge mclk) disable iff (rst)
    $rose(run) && $past(has_pred) |-> $past(pred_up))
    else $error("Ramp began before predecessor good");
  AST_DN_ORDER: assert property (@(posedge mclk) disable iff (rst)
    state == ST_FALL && $past(state) == ST_WAIT_DN && $past(has_succ)
      |-> $past(succ_dn))
    else $error("Turn-off before successor off");
  AST_PG_EVENT: assert property (@(posedge mclk) disable iff (rst)
    state == ST_RAMP && pgood && !fault && seq_on && !peer_flt
      |=> tx_pend && tx_type == EV_PG && run)
    else $error("Power-good event not queued");
  AST_FAULT_BCAST: assert property (@(posedge mclk) disable iff (rst)
    state inside {ST_RAMP, ST_ON} && fault |=> !run && tx_pend && tx_type == EV_FLT
      ##1 state == ST_FAULT || state == ST_OFF)
    else $error("Fault not broadcast");
  AST_TRACK: assert property (@(posedge mclk) disable iff (rst)
    loaded |-> track_en == (cfg.role == ROLE_TRACK) && (track_en -> !auto_mode))
    else $error("Tracking role mismatch");
  AST_TRACK_STRAP: assert property (@(posedge mclk) disable iff (rst)
    $rose(loaded) |-> track_en == ($past(cfg_strap.res_fit)
      && $past(cfg_strap.index) >= 5'h0C && $past(cfg_strap.index) <= 5'h0E))
    else $error("Tracking not from config strap");
  AST_DRIVE_LOW: assert property (@(posedge mclk) disable iff (rst)
    tx_go |=> rx_busy && rx_bit == 4'h0)
    else $error("Own start bit not seen on line");
  CV_SEQ_UP: cover property (@(posedge mclk) disable iff (rst)
    state == ST_WAIT_UP && has_pred ##[1:1000] state == ST_ON);
  CV_SEQ_DN: cover property (@(posedge mclk) disable iff (rst)
    state == ST_WAIT_DN && has_succ ##[1:1000] state == ST_OFF);
  CV_FAULT: cover property (@(posedge mclk) disable iff (rst)
    state == ST_FAULT ##[1:1000] state == ST_OFF);
  CV_LOSE: cover property (@(posedge mclk) disable iff (rst) lose);
endmodule // sap_seq

// >>> tb/sap_peer.sv
// Peer converter on the shared event wire: sends one frame, records every frame seen.
// Assumes a pull-up wire: line is high unless some party pulls it low.
`timescale 1ns/1ns
module sap_peer
  import sap_pkg::*;
(
  input wire logic mclk,
  input wire logic line,
  input wire logic go,
  input wire logic [8:0] tx_word,
  output logic oe_n,
  output logic busy,
  output logic [8:0] rx_word,
  output int rx_cnt
);
  logic [9:0] frame;
  logic [9:0] rsh;
  logic rx_on;
  int bit_n;
  int cyc;
  int rbit;
  int rcyc;
  initial
  begin
    oe_n = 1'b1;
    busy = 1'b0;
    rx_on = 1'b0;
    rx_cnt = 0;
    rx_word = 9'h000;
  end
  // Frame capture, sampled mid-bit
  always @(posedge mclk)
  begin
    if (!rx_on && !line)
    begin
      rx_on <= 1'b1;
      rcyc <= 0;
      rbit <= 0;
    end
    else if (rx_on)
    begin
      if (rcyc == EV_BIT_CYC / 2)
        rsh <= {rsh[8:0], line};
      if (rcyc == EV_BIT_CYC - 1)
      begin
        rcyc <= 0;
        rbit <= rbit + 1;
        if (rbit == 9)
        begin
          rx_on <= 1'b0;
          rx_word <= rsh[8:0];
          rx_cnt <= rx_cnt + 1;
        end
      end
      else
        rcyc <= rcyc + 1;
    end
  end
  // Sender only pulls low; waits for an idle wire first
  always @(posedge mclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      frame <= {1'b0, tx_word};
      bit_n <= -1;
    end
    else if (busy && bit_n < 0)
    begin
      if (line && !rx_on)
      begin
        bit_n <= 0;
        cyc <= 0;
        oe_n <= 1'b0;
      end
    end
    else if (busy)
    begin
      if (cyc == EV_BIT_CYC - 1)
      begin
        cyc <= 0;
        if (bit_n == 9)
        begin
          busy <= 1'b0;
          oe_n <= 1'b1;
        end
        else
        begin
          bit_n <= bit_n + 1;
          oe_n <= frame[8 - bit_n];
        end
      end
      else
        cyc <= cyc + 1;
    end
  end
endmodule // sap_peer

// >>> tb/sap_seq_bench.sv
// Self-checking bench for the strap, phase and sequencing block.
// Assumes one peer model on a pulled-up event wire and one shared clock.
`timescale 1ns/1ns
module sap_seq_bench
  import sap_pkg::*;
;
  logic mclk, rst, enable, pgood, off_done, fault, ev_out, ev_oe_n, run, track_en;
  logic reg_we, reg_re, go, p_oe_n, p_busy;
  sap_strap_t addr_strap, cfg_strap;
  sap_sync_t sync_mode;
  logic [6:0] bus_addr;
  logic [4:0] phase;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [8:0] tx_word, rx_word;
  int rx_cnt, num_errors, n_tests, cycles;
  wire ev_in = ev_oe_n & p_oe_n;
  sap_seq dut (.mclk(mclk), .rst(rst), .addr_strap(addr_strap), .cfg_strap(cfg_strap),
    .enable(enable), .pgood(pgood), .off_done(off_done), .fault(fault), .ev_in(ev_in),
    .ev_out(ev_out), .ev_oe_n(ev_oe_n), .run(run), .track_en(track_en),
    .sync_mode(sync_mode), .bus_addr(bus_addr), .phase(phase), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  // One clock feeds both parties
  sap_peer peer (.mclk(mclk), .line(ev_in), .go(go), .tx_word(tx_word), .oe_n(p_oe_n),
    .busy(p_busy), .rx_word(rx_word), .rx_cnt(rx_cnt));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      test_done();
    end
  end
  task do_reset(input sap_strap_t a, input sap_strap_t c);
    @(posedge mclk);
    rst <= 1'b1;
    addr_strap <= a;
    cfg_strap <= c;
    {enable, pgood, fault, off_done} <= 4'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_run(input logic v);
    for (int i = 0; i < 40 && run !== v; i++) @(posedge mclk);
  endtask
  task wait_frame(input int c0);
    for (int i = 0; i < 3000 && rx_cnt == c0; i++) @(posedge mclk);
  endtask
  // Peer frame; its own capture marks the end of the frame
  task send(input logic [8:0] w);
    int c0;
    c0 = rx_cnt;
    @(posedge mclk);
    go <= 1'b1;
    tx_word <= w;
    @(posedge mclk);
    go <= 1'b0;
    wait_frame(c0);
  endtask
  task t_strap;
    int x;
    logic [6:0] ea;
    logic [2:0] er;
    for (int k = 0; k < 18; k++)
    begin
      x = (k < 3) ? 0 : ((k - 3) * 29) / 14;
      er = (k < 3) ? 3'h0 : 3'((k - 3) / 3);
      if (k < 3)
        do_reset('{1'b0, 2'(k), 5'h00}, '{1'b0, 2'(k), 5'h00});
      else
        do_reset('{1'b1, 2'h0, 5'(x)}, '{1'b1, 2'h0, 5'(k - 3)});
      ea = (k < 3) ? ADDR_BASE + 7'(k) : ADDR_BASE + 7'(x);
      chk("bus_addr", {9'h000, ea}, {9'h000, bus_addr});
      chk("phase", {12'h000, ea[2:0], 1'b0}, {11'h000, phase});
      chk("sync_mode", 16'((k < 3 ? k : k - 3) % 3), {14'h0, sync_mode});
      chk("track_en", {15'h0, er == 3'h4}, {15'h0, track_en});
      rd(REG_STRAP);
      chk("role", {13'h0, er}, {13'h0, d[10:8]});
    end
    $display("test strap done");
  endtask
  // Middle member 0x2D between peers 0x2C and 0x2E
  task t_middle;
    int c0;
    do_reset('{1'b1, 2'h0, 5'h0D}, '{1'b1, 2'h0, 5'h0A});
    @(posedge mclk) enable <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("run held", 16'h0, {15'h0, run});
    wr(REG_CTRL, 16'h0001);
    wr(REG_PHASE, 16'h0003);
    repeat (3) @(posedge mclk);
    chk("forced phase", 16'h000A, {11'h000, phase});
    chk("ev_out", 16'h0, {15'h0, ev_out});
    send({EV_PG, 7'h2C});
    wait_run(1'b1);
    chk("run up", 16'h1, {15'h0, run});
    c0 = rx_cnt;
    @(posedge mclk) {pgood, off_done} <= 2'b10;
    wait_frame(c0);
    chk("pg frame", {7'h0, EV_PG, 7'h2D}, {7'h0, rx_word});
    @(posedge mclk) enable <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("run kept", 16'h1, {15'h0, run});
    send({EV_OFF, 7'h2E});
    wait_run(1'b0);
    chk("run down", 16'h0, {15'h0, run});
    c0 = rx_cnt;
    @(posedge mclk) {pgood, off_done} <= 2'b01;
    wait_frame(c0);
    chk("off frame", {7'h0, EV_OFF, 7'h2D}, {7'h0, rx_word});
    $display("test middle done");
  endtask
  task t_fault;
    int c0;
    do_reset('{1'b0, 2'h0, 5'h00}, '{1'b1, 2'h0, 5'h03});
    @(posedge mclk) enable <= 1'b1;
    wait_run(1'b1);
    chk("first up", 16'h1, {15'h0, run});
    c0 = rx_cnt;
    @(posedge mclk) {pgood, off_done} <= 2'b10;
    wait_frame(c0);
    c0 = rx_cnt;
    @(posedge mclk) fault <= 1'b1;
    wait_run(1'b0);
    chk("fault stop", 16'h0, {15'h0, run});
    wait_frame(c0);
    chk("fault frame", {7'h0, EV_FLT, 7'h20}, {7'h0, rx_word});
    $display("test fault done");
  endtask
  // Chain mode with a far, non-consecutive predecessor
  task t_chain;
    do_reset('{1'b0, 2'h1, 5'h00}, '{1'b0, 2'h0, 5'h00});
    wr(REG_CTRL, 16'h0007);
    wr(REG_PHASE, 16'h0010);
    wr(REG_PHASE, 16'h0011);
    repeat (3) @(posedge mclk);
    chk("phase", 16'h0010, {11'h000, phase});
    rd(REG_PHASE);
    chk("phase reg", 16'h0010, d);
    rd(4'hF);
    chk("unmapped", 16'h0000, d);
    wr(REG_PRED, 16'h0085);
    @(posedge mclk) enable <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("chain held", 16'h0, {15'h0, run});
    send({EV_PG, 7'h05});
    wait_run(1'b1);
    chk("chain up", 16'h1, {15'h0, run});
    send({EV_FLT, 7'h05});
    wait_run(1'b0);
    chk("follow stop", 16'h0, {15'h0, run});
    rd(REG_STATUS);
    chk("fault state", {13'h0, ST_FAULT}, {13'h0, d[2:0]});
    wr(REG_CTRL, 16'h000F);
    repeat (10) @(posedge mclk);
    chk("restart held", 16'h0, {15'h0, run});
    send({EV_PG, 7'h05});
    wait_run(1'b1);
    chk("restart up", 16'h1, {15'h0, run});
    $display("test chain done");
  endtask
  initial
  begin
    {rst, enable, pgood, off_done, fault, reg_we, reg_re, go} = 8'h90;
    addr_strap = '0;
    cfg_strap = '0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    tx_word = 9'h000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_strap();
    t_middle();
    t_fault();
    t_chain();
    test_done();
  end
endmodule // sap_seq_bench
